// File: logic/pgm_pkg.sv
// Functional notes
// [R1] Second-bank bit 7 clear: control_input_5 joins the tree; set: ignored.
// [R2] Second-bank bit 6 clear: control_input_4 joins the tree; set: ignored.
// [R3] Second-bank bit 5 clear: control_input_2 joins the tree; set: ignored.
// [R4] Second-bank bit 4 clear: control_input_1 joins the tree; set: ignored.
// [R5] Second-bank bit 3 clear: termination regulator good joins the tree.
// [R6] Second-bank bit 2 clear: shared switch-or-regulator good joins the tree.
// [R7] One-time memory picks load_switch_b_two or aux_regulator_one as shared source.
// [R8] Second-bank bit 1 clear: load_switch_b_one good joins the tree.
// [R9] Second-bank bit 0 clear: aux_regulator_three good joins the tree.
// [R10] Output c first-bank bit 7 clear: aux_regulator_two good joins the tree.
// [R11] Output c first-bank bit 6 clear: load_switch_a_one good joins the tree.
// [R12] Output c first-bank bit 5 clear: step_down_six good joins the tree.
// [R13] Output c first-bank bit 4 clear: step_down_five good joins the tree.
// [R14] Output c first-bank bit 3 clear: step_down_four good joins the tree.
// [R15] Output c first-bank bit 2 clear: step_down_three good joins the tree.
// [R16] Output c first-bank bit 1 clear: step_down_two good joins the tree.
// [R17] Output c first-bank bit 0 clear: step_down_one good joins the tree.
// [R18] Status output high only while every unmasked source of its tree is good.
// [R19] Mask bits are software read/write and reset from one-time memory values.
package pgm_pkg;

   // Register indices as printed; byte address is four times the index
   localparam logic [7:0]  IDX_B_SECOND   = 8'ha9;
   localparam logic [7:0]  IDX_C_FIRST    = 8'haa;
   localparam logic [7:0]  IDX_C_SECOND   = 8'hab;
   localparam logic [7:0]  IDX_STATUS     = 8'hb0;
   localparam int          ADDR_W         = 12;
   localparam logic [11:0] ADDR_B_SECOND  = {2'h0, IDX_B_SECOND, 2'h0};
   localparam logic [11:0] ADDR_C_FIRST   = {2'h0, IDX_C_FIRST, 2'h0};
   localparam logic [11:0] ADDR_C_SECOND  = {2'h0, IDX_C_SECOND, 2'h0};
   localparam logic [11:0] ADDR_STATUS    = {2'h0, IDX_STATUS, 2'h0};

   // Constant reset value; real value is loaded from one-time memory after release
   localparam logic [7:0]  MASK_RST       = 8'h00;

   // Status register field positions
   localparam int          ST_OUT_B       = 0;
   localparam int          ST_OUT_C       = 1;
   localparam int          ST_SHARED_SEL  = 2;
   localparam int          ST_LOADED      = 3;

   // Power-good and control pin inputs, high means good or asserted
   typedef struct packed {
      logic control_input_5;
      logic control_input_4;
      logic control_input_2;
      logic control_input_1;
      logic termination_pg;
      logic load_switch_b_two_pg;
      logic aux_regulator_one_pg;
      logic load_switch_b_one_pg;
      logic aux_regulator_three_pg;
      logic aux_regulator_two_pg;
      logic load_switch_a_one_pg;
      logic step_down_six_pg;
      logic step_down_five_pg;
      logic step_down_four_pg;
      logic step_down_three_pg;
      logic step_down_two_pg;
      logic step_down_one_pg;
   } pgm_sources_s;

   // One-time memory image: mask defaults and shared source pick
   typedef struct packed {
      logic [7:0] b_second_mask;
      logic [7:0] c_first_mask;
      logic [7:0] c_second_mask;
      logic       shared_is_aux_one;
   } pgm_otp_s;

   // A tree is good when each source is good or masked off
   function automatic logic pgm_tree(input logic [7:0] src, input logic [7:0] mask);
      pgm_tree = &(src | mask);
   endfunction : pgm_tree

endpackage : pgm_pkg

// File: logic/pgm_regs.sv
`timescale 1ns/1ps
`default_nettype none
module pgm_regs
   import pgm_pkg::*;
(
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [ADDR_W-1:0]  paddr,
   input  wire logic [31:0]        pwdata,
   input  wire logic [3:0]         pstrb,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Power-good sources and one-time memory image
   input  wire pgm_sources_s       sources,
   input  wire pgm_otp_s           otp,
   // Status outputs
   output logic                    status_output_b,
   output logic                    status_output_c
);

   logic [7:0]  second_output_b_mask;
   logic [7:0]  first_output_c_mask;
   logic [7:0]  second_output_c_mask;
   logic        shared_is_aux_one;
   logic        load_pending;
   logic        shared_pg;
   logic [7:0]  second_bank_src;
   logic [7:0]  first_bank_src;
   logic        wr_access;
   logic        mapped;
   logic [31:0] next_rdata;

   // Shared source chosen by one-time memory
   assign shared_pg = shared_is_aux_one ? sources.aux_regulator_one_pg
                                        : sources.load_switch_b_two_pg; // [R7]

   // Second bank order: control 5,4,2,1, termination, shared, switch b one, aux three
   assign second_bank_src = {sources.control_input_5,        // [R1]
                             sources.control_input_4,        // [R2]
                             sources.control_input_2,        // [R3]
                             sources.control_input_1,        // [R4]
                             sources.termination_pg,         // [R5]
                             shared_pg,                      // [R6]
                             sources.load_switch_b_one_pg,   // [R8]
                             sources.aux_regulator_three_pg}; // [R9]

   // First bank order: aux two, switch a one, step-down six down to one
   assign first_bank_src = {sources.aux_regulator_two_pg,    // [R10]
                            sources.load_switch_a_one_pg,    // [R11]
                            sources.step_down_six_pg,        // [R12]
                            sources.step_down_five_pg,       // [R13]
                            sources.step_down_four_pg,       // [R14]
                            sources.step_down_three_pg,      // [R15]
                            sources.step_down_two_pg,        // [R16]
                            sources.step_down_one_pg};       // [R17]

   // Address decode; only whole aligned words are mapped
   always_comb begin
      unique case (paddr)
         ADDR_B_SECOND, ADDR_C_FIRST, ADDR_C_SECOND, ADDR_STATUS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Zero wait states; error only in the access phase of an unmapped word
   assign pready    = 1'b1;
   assign pslverr   = psel & penable & ~mapped;
   assign wr_access = psel & penable & pwrite & mapped & pstrb[0];

   // One-time memory load happens on the first edge after reset release.
   // Async reset may only take a constant, so the strap is caught here instead.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_pending <= 1'b1;
      end else begin
         load_pending <= 1'b0;
      end
   end

   // Shared source pick, held from the load onward
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shared_is_aux_one <= 1'b0;
      end else if (load_pending) begin
         shared_is_aux_one <= otp.shared_is_aux_one; // [R7]
      end
   end

   // Mask registers: load from memory image, then software owns them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         second_output_b_mask <= MASK_RST;
         first_output_c_mask  <= MASK_RST;
         second_output_c_mask <= MASK_RST;
      end else if (load_pending) begin
         second_output_b_mask <= otp.b_second_mask; // [R19]
         first_output_c_mask  <= otp.c_first_mask;
         second_output_c_mask <= otp.c_second_mask;
      end else if (wr_access) begin
         if (paddr == ADDR_B_SECOND) begin
            second_output_b_mask <= pwdata[7:0]; // [R19]
         end
         if (paddr == ADDR_C_FIRST) begin
            first_output_c_mask <= pwdata[7:0];
         end
         if (paddr == ADDR_C_SECOND) begin
            second_output_c_mask <= pwdata[7:0];
         end
      end
   end

   // Read mux; unused upper bits read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (paddr)
         ADDR_B_SECOND: next_rdata[7:0] = second_output_b_mask;
         ADDR_C_FIRST:  next_rdata[7:0] = first_output_c_mask;
         ADDR_C_SECOND: next_rdata[7:0] = second_output_c_mask;
         ADDR_STATUS: begin
            next_rdata[ST_OUT_B]      = status_output_b;
            next_rdata[ST_OUT_C]      = status_output_c;
            next_rdata[ST_SHARED_SEL] = shared_is_aux_one;
            next_rdata[ST_LOADED]     = ~load_pending;
         end
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Read data captured in the setup phase so it is a flop in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= next_rdata;
      end
   end

   // Status trees; registered to keep the pins glitch-free across the mask OR
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_output_b <= 1'b0;
         status_output_c <= 1'b0;
      end else begin
         status_output_b <= pgm_tree(second_bank_src, second_output_b_mask); // [R18]
         status_output_c <= pgm_tree(second_bank_src, second_output_c_mask) &
                            pgm_tree(first_bank_src, first_output_c_mask);   // [R18]
      end
   end

   // Assertion helpers: sources that are bad and not masked off
   logic [7:0] b_bad;
   logic [7:0] c2_bad;
   logic [7:0] c1_bad;
   assign b_bad  = ~second_bank_src & ~second_output_b_mask;
   assign c2_bad = ~second_bank_src & ~second_output_c_mask;
   assign c1_bad = ~first_bank_src & ~first_output_c_mask;

   // Checks on the trees and the register file
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_control_input_5_out_b: assert property ( // [R1]
      !second_output_b_mask[7] && !sources.control_input_5 |=> !status_output_b)
      else $error("control 5 low did not drop output b");

   chk_control_input_4_out_c: assert property ( // [R2]
      !second_output_c_mask[6] && !sources.control_input_4 |=> !status_output_c)
      else $error("control 4 low did not drop output c");

   chk_control_input_2_out_b: assert property ( // [R3]
      !second_output_b_mask[5] && !sources.control_input_2 |=> !status_output_b)
      else $error("control 2 low did not drop output b");

   chk_control_input_1_out_c: assert property ( // [R4]
      !second_output_c_mask[4] && !sources.control_input_1 |=> !status_output_c)
      else $error("control 1 low did not drop output c");

   chk_term_out_b: assert property ( // [R5]
      !second_output_b_mask[3] && !sources.termination_pg |=> !status_output_b)
      else $error("termination fault did not drop output b");

   chk_shared_out_c: assert property ( // [R6]
      !second_output_c_mask[2] && !shared_pg |=> !status_output_c)
      else $error("shared source fault did not drop output c");

   chk_shared_pick: assert property ( // [R7]
      presetn && load_pending |=> shared_is_aux_one == $past(otp.shared_is_aux_one) ##1
      $stable(shared_is_aux_one))
      else $error("shared source pick not taken from memory image");

   chk_load_switch_b_one_out_b: assert property ( // [R8]
      !second_output_b_mask[1] && !sources.load_switch_b_one_pg |=> !status_output_b)
      else $error("switch b one fault did not drop output b");

   chk_aux3_out_c: assert property ( // [R9]
      !second_output_c_mask[0] && !sources.aux_regulator_three_pg |=> !status_output_c)
      else $error("aux three fault did not drop output c");

   chk_aux2_out_c: assert property ( // [R10]
      !first_output_c_mask[7] && !sources.aux_regulator_two_pg |=> !status_output_c)
      else $error("aux two fault did not drop output c");

   chk_first_bank_c: assert property ( // [R11] [R12] [R13] [R14] [R15] [R16] [R17]
      (first_bank_src | first_output_c_mask) != 8'hff |=> !status_output_c)
      else $error("unmasked first bank fault did not drop output c");

   chk_all_good: assert property ( // [R18]
      presetn && ((second_bank_src | second_output_c_mask) == 8'hff) &&
      ((first_bank_src | first_output_c_mask) == 8'hff) |=> status_output_c)
      else $error("output c low with every unmasked source good");

   chk_masked_ignored: assert property ( // [R18]
      presetn && second_output_b_mask == 8'hff |=> status_output_b)
      else $error("fully masked output b not high");

   chk_otp_load: assert property ( // [R19]
      presetn && load_pending |=> second_output_b_mask == $past(otp.b_second_mask) &&
      first_output_c_mask == $past(otp.c_first_mask) &&
      second_output_c_mask == $past(otp.c_second_mask))
      else $error("masks not loaded from memory image");

   chk_sw_write: assert property ( // [R19]
      wr_access && !load_pending && paddr == ADDR_C_FIRST |=>
      first_output_c_mask == $past(pwdata[7:0]))
      else $error("write to output c first mask not stored");

   chk_read_back: assert property ( // [R19]
      psel && !penable && !pwrite && paddr == ADDR_B_SECOND ##1 psel && penable |->
      prdata == {24'h000000, $past(second_output_b_mask)})
      else $error("output b mask read back wrong");

   // Each second-bank source also reaches the other status output
   chk_control_input_5_out_c: assert property ( // [R1]
      !second_output_c_mask[7] && !sources.control_input_5 |=> !status_output_c)
      else $error("control 5 low did not drop output c");

   chk_control_input_4_out_b: assert property ( // [R2]
      !second_output_b_mask[6] && !sources.control_input_4 |=> !status_output_b)
      else $error("control 4 low did not drop output b");

   chk_control_input_2_out_c: assert property ( // [R3]
      !second_output_c_mask[5] && !sources.control_input_2 |=> !status_output_c)
      else $error("control 2 low did not drop output c");

   chk_control_input_1_out_b: assert property ( // [R4]
      !second_output_b_mask[4] && !sources.control_input_1 |=> !status_output_b)
      else $error("control 1 low did not drop output b");

   chk_term_out_c: assert property ( // [R5]
      !second_output_c_mask[3] && !sources.termination_pg |=> !status_output_c)
      else $error("termination fault did not drop output c");

   chk_shared_out_b: assert property ( // [R6]
      !second_output_b_mask[2] && !shared_pg |=> !status_output_b)
      else $error("shared source fault did not drop output b");

   chk_load_switch_b_one_out_c: assert property ( // [R8]
      !second_output_c_mask[1] && !sources.load_switch_b_one_pg |=> !status_output_c)
      else $error("switch b one fault did not drop output c");

   chk_aux3_out_b: assert property ( // [R9]
      !second_output_b_mask[0] && !sources.aux_regulator_three_pg |=> !status_output_b)
      else $error("aux three fault did not drop output b");

   // A set mask bit hides a bad source; sampled reset keeps the release edge out
   chk_control_input_5_masked: assert property ( // [R1]
      presetn && second_output_b_mask[7] && !sources.control_input_5 &&
      b_bad == 8'h00 |=> status_output_b)
      else $error("masked control 5 still dropped output b");

   chk_control_input_4_masked: assert property ( // [R2]
      presetn && second_output_b_mask[6] && !sources.control_input_4 &&
      b_bad == 8'h00 |=> status_output_b)
      else $error("masked control 4 still dropped output b");

   chk_control_input_2_masked: assert property ( // [R3]
      presetn && second_output_b_mask[5] && !sources.control_input_2 &&
      b_bad == 8'h00 |=> status_output_b)
      else $error("masked control 2 still dropped output b");

   chk_control_input_1_masked: assert property ( // [R4]
      presetn && second_output_b_mask[4] && !sources.control_input_1 &&
      b_bad == 8'h00 |=> status_output_b)
      else $error("masked control 1 still dropped output b");

   chk_term_masked: assert property ( // [R5]
      presetn && second_output_b_mask[3] && !sources.termination_pg &&
      b_bad == 8'h00 |=> status_output_b)
      else $error("masked termination still dropped output b");

   chk_shared_masked: assert property ( // [R6]
      presetn && second_output_b_mask[2] && !shared_pg &&
      b_bad == 8'h00 |=> status_output_b)
      else $error("masked shared source still dropped output b");

   chk_load_switch_b_one_masked: assert property ( // [R8]
      presetn && second_output_b_mask[1] && !sources.load_switch_b_one_pg &&
      b_bad == 8'h00 |=> status_output_b)
      else $error("masked switch b one still dropped output b");

   chk_aux3_masked: assert property ( // [R9]
      presetn && second_output_b_mask[0] && !sources.aux_regulator_three_pg &&
      b_bad == 8'h00 |=> status_output_b)
      else $error("masked aux three still dropped output b");

   chk_aux2_masked: assert property ( // [R10]
      presetn && first_output_c_mask[7] && !sources.aux_regulator_two_pg &&
      c1_bad == 8'h00 && c2_bad == 8'h00 |=> status_output_c)
      else $error("masked aux two still dropped output c");

   chk_load_switch_a_one_masked: assert property ( // [R11]
      presetn && first_output_c_mask[6] && !sources.load_switch_a_one_pg &&
      c1_bad == 8'h00 && c2_bad == 8'h00 |=> status_output_c)
      else $error("masked switch a one still dropped output c");

   chk_step6_masked: assert property ( // [R12]
      presetn && first_output_c_mask[5] && !sources.step_down_six_pg &&
      c1_bad == 8'h00 && c2_bad == 8'h00 |=> status_output_c)
      else $error("masked step-down six still dropped output c");

   chk_step5_masked: assert property ( // [R13]
      presetn && first_output_c_mask[4] && !sources.step_down_five_pg &&
      c1_bad == 8'h00 && c2_bad == 8'h00 |=> status_output_c)
      else $error("masked step-down five still dropped output c");

   chk_step4_masked: assert property ( // [R14]
      presetn && first_output_c_mask[3] && !sources.step_down_four_pg &&
      c1_bad == 8'h00 && c2_bad == 8'h00 |=> status_output_c)
      else $error("masked step-down four still dropped output c");

   chk_step3_masked: assert property ( // [R15]
      presetn && first_output_c_mask[2] && !sources.step_down_three_pg &&
      c1_bad == 8'h00 && c2_bad == 8'h00 |=> status_output_c)
      else $error("masked step-down three still dropped output c");

   chk_step2_masked: assert property ( // [R16]
      presetn && first_output_c_mask[1] && !sources.step_down_two_pg &&
      c1_bad == 8'h00 && c2_bad == 8'h00 |=> status_output_c)
      else $error("masked step-down two still dropped output c");

   chk_step1_masked: assert property ( // [R17]
      presetn && first_output_c_mask[0] && !sources.step_down_one_pg &&
      c1_bad == 8'h00 && c2_bad == 8'h00 |=> status_output_c)
      else $error("masked step-down one still dropped output c");

   // The picked source speaks for the shared slot on output b
   chk_pick_aux_one: assert property ( // [R7]
      shared_is_aux_one && !sources.aux_regulator_one_pg && !second_output_b_mask[2]
      |=> !status_output_b)
      else $error("picked aux one fault did not drop output b");

   chk_pick_switch: assert property ( // [R7]
      !shared_is_aux_one && !sources.load_switch_b_two_pg && !second_output_b_mask[2]
      |=> !status_output_b)
      else $error("picked switch b two fault did not drop output b");

   chk_sw_write_b: assert property ( // [R19]
      wr_access && !load_pending && paddr == ADDR_B_SECOND |=>
      second_output_b_mask == $past(pwdata[7:0]))
      else $error("write to output b second mask not stored");

   chk_sw_write_c2: assert property ( // [R19]
      wr_access && !load_pending && paddr == ADDR_C_SECOND |=>
      second_output_c_mask == $past(pwdata[7:0]))
      else $error("write to output c second mask not stored");

   // Main scenarios
   cov_write_mask:  cover property (wr_access && paddr == ADDR_C_SECOND);
   cov_read_status: cover property (psel && penable && !pwrite && paddr == ADDR_STATUS);
   cov_c_rises:     cover property (!status_output_c ##1 status_output_c);
   cov_unmapped:    cover property (pslverr);
   cov_b_falls:     cover property (status_output_b ##1 !status_output_b);

endmodule : pgm_regs
`default_nettype wire

// File: tb/pgm_watch.sv
`timescale 1ns/1ps
`default_nettype none
module pgm_watch
   import pgm_pkg::*;
(
   // Clock
   input  wire logic pclk,
   // Status outputs under watch
   input  wire logic status_output_b,
   input  wire logic status_output_c,
   // Levels as the system last saw them
   output var logic  seen_b,
   output var logic  seen_c
);
   // System logic only samples the pins; it never drives the device back
   always_ff @(posedge pclk) begin
      seen_b <= status_output_b;
      seen_c <= status_output_c;
   end
endmodule : pgm_watch
`default_nettype wire

// File: tb/test_power_good_output_mask_regs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("[ERR] %s expected %h seen %h", what, exp, got); end end
module test_power_good_output_mask_regs;
   import pgm_pkg::*;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic              out_b, out_c, seen_b, seen_c, err;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic [3:0]        pstrb;
   pgm_sources_s      src;
   pgm_otp_s          otp;
   logic [ADDR_W-1:0] regs [3];
   int                n_errors, checks, cyc;

   pgm_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sources(src), .otp(otp),
      .status_output_b(out_b), .status_output_c(out_c));
   pgm_watch u_watch (.pclk(pclk), .status_output_b(out_b), .status_output_c(out_c),
      .seen_b(seen_b), .seen_c(seen_c));

   // Free-running clock, 8 ns period
   always #4 pclk = ~pclk;

   // Hang guard: the whole sequence needs well under this many cycles
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 8000) begin
         n_errors++;
         finish_test();
      end
   end

   // One APB transfer; request held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      // No cycle count assumed; pready seen high ends this wait, else the hang guard
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Source change needs one register stage, mask write two, plus the watcher
   task automatic settle();
      repeat (4) @(posedge pclk);
   endtask : settle

   task automatic set_src(input int idx, input logic v);
      @(posedge pclk);
      src[idx] <= v;
      settle();
   endtask : set_src

   task automatic do_reset(input logic [7:0] b, input logic [7:0] c1, input logic [7:0] c2,
                           input logic aux);
      @(posedge pclk);
      presetn <= 1'b0;
      otp     <= '{b, c1, c2, aux};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask : do_reset

   // Second-bank bit to source position, shared slot wired to aux one
   function automatic int bank2_src(input int i);
      bank2_src = (i >= 3) ? i + 9 : ((i == 2) ? 10 : i + 8);
   endfunction : bank2_src

   task automatic finish_test();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hf;
      src = '1;
      otp = '0;
      regs = '{ADDR_B_SECOND, ADDR_C_FIRST, ADDR_C_SECOND};
      do_reset(8'h5a, 8'ha5, 8'hc3, 1'b1);
      // Masks come up from the one-time image, not a constant
      apb(1'b0, ADDR_B_SECOND, 8'h00);
      `CHK("b_second", 32'h5a, rd)
      apb(1'b0, ADDR_C_FIRST, 8'h00);
      `CHK("c_first", 32'ha5, rd)
      apb(1'b0, ADDR_C_SECOND, 8'h00);
      `CHK("c_second", 32'hc3, rd)
      apb(1'b0, ADDR_STATUS, 8'h00);
      `CHK("shared_pick", 1'b1, rd[ST_SHARED_SEL])
      `CHK("status_word", 32'h0000_000f, rd)
      `CHK("all_good_b", 1'b1, seen_b)
      // Every mask bit writes and reads back both ways
      for (int r = 0; r < 3; r++) begin
         apb(1'b1, regs[r], 8'hff);
         apb(1'b0, regs[r], 8'h00);
         `CHK("mask_ones", 32'hff, rd)
         apb(1'b1, regs[r], 8'h00);
         apb(1'b0, regs[r], 8'h00);
         `CHK("mask_zeros", 32'h00, rd)
      end
      // Write without the low byte strobe leaves the mask alone
      pstrb <= 4'h0;
      apb(1'b1, ADDR_B_SECOND, 8'hff);
      pstrb <= 4'hf;
      apb(1'b0, ADDR_B_SECOND, 8'h00);
      `CHK("strobe_off", 32'h00, rd)
      // Unmapped place answers with an error and zero data
      apb(1'b0, 12'h2b0, 8'h00);
      `CHK("unmapped_err", 1'b1, err)
      `CHK("unmapped_data", 32'h0, rd)
      // Second bank: a bad source pulls both trees low until masked
      for (int i = 0; i < 8; i++) begin
         set_src(bank2_src(i), 1'b0);
         `CHK("b2_in_b", 1'b0, seen_b)
         `CHK("b2_in_c", 1'b0, seen_c)
         apb(1'b1, ADDR_B_SECOND, 8'(1 << i));
         apb(1'b1, ADDR_C_SECOND, 8'(1 << i));
         settle();
         `CHK("b2_out_b", 1'b1, seen_b)
         `CHK("b2_out_c", 1'b1, seen_c)
         src <= '1;
         apb(1'b1, ADDR_B_SECOND, 8'h00);
         apb(1'b1, ADDR_C_SECOND, 8'h00);
      end
      // Unpicked switch has no say in the shared slot
      set_src(11, 1'b0);
      `CHK("unpicked_b", 1'b1, seen_b)
      set_src(11, 1'b1);
      // First bank feeds output c only
      for (int i = 0; i < 8; i++) begin
         set_src(i, 1'b0);
         `CHK("b1_not_b", 1'b1, seen_b)
         `CHK("b1_in_c", 1'b0, seen_c)
         apb(1'b1, ADDR_C_FIRST, 8'(1 << i));
         settle();
         `CHK("b1_out_c", 1'b1, seen_c)
         src <= '1;
         apb(1'b1, ADDR_C_FIRST, 8'h00);
      end
      // Second reset picks the switch as shared source
      do_reset(8'h00, 8'h00, 8'h00, 1'b0);
      apb(1'b0, ADDR_STATUS, 8'h00);
      `CHK("shared_pick2", 1'b0, rd[ST_SHARED_SEL])
      set_src(10, 1'b0);
      `CHK("aux_unpicked", 1'b1, seen_b)
      set_src(11, 1'b0);
      `CHK("switch_picked", 1'b0, seen_b)
      finish_test();
   end
endmodule : test_power_good_output_mask_regs
`default_nettype wire
